// ===== core/i2cmc_ctrl.sv
// Purpose: mode and enable control of a two-wire serial interface
// Assumes: apb master, pins synchronised here, acknowledge bits omitted
// Notes: received bytes pass an 8-word fifo read at the receive register
//
// Functional notes
// - enable 0 halts the block and hands both pins back to port use.
// - enable 1 permits transfers and drives clock and data as bus pins.
// - receive register read restarts master or sync slave reception if block bit 0, halts if 1.
// - arbitration loss in two-wire master mode clears master and transmit.
// - slave address match with read bit sets transmit select.
// - master and transmit bits together select one of four modes.

`timescale 1ns/1ns

module i2cmc_ctrl #(
	parameter int HALF_CYC = i2cmc_pkg::HALF_CYC,
	parameter int FIFO_DEPTH = i2cmc_pkg::FIFO_DEPTH
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	output logic pins_bus_sel
);

	// --------------------------------------------------------------
	// state
	// --------------------------------------------------------------
	typedef struct packed {
		logic en;
		logic next_receive_block;
		logic master_select_bit;
		logic transmit_select_bit;
		logic fmt_sync;
		logic [6:0] own_slave_address;
		logic [7:0] txd;
		logic tx_full;
		logic arb_lost;
		logic ovr;
		logic addr_hit;
		logic rx_stop;
		logic addr_phase;
		i2cmc_pkg::i2cmc_state_type state;
		logic [3:0] bitcnt;
		logic [7:0] shreg;
		logic [i2cmc_pkg::DIV_W-1:0] div;
		logic phase;
		logic scl_prev;
		logic sda_prev;
		logic push;
		logic [7:0] push_data;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic scl_out;
		logic scl_oe;
		logic sda_out;
		logic sda_oe;
		logic pins_sel;
	} i2cmc_ctrl_type;

	i2cmc_ctrl_type s_q, s_d;

	logic [1:0] pins_s;
	logic scl_s, sda_s;
	logic fifo_in_ready, fifo_out_valid, fifo_pop;
	logic [7:0] fifo_out_data;
	logic [$clog2(FIFO_DEPTH):0] fifo_level;
	logic acc, acc_done, wr_done, rd_done;
	logic [1:0] mode;

	localparam logic [i2cmc_pkg::DIV_W-1:0] HALF_LD =
		i2cmc_pkg::DIV_W'(HALF_CYC - 1);

	// --------------------------------------------------------------
	// pin synchroniser and receive fifo
	// --------------------------------------------------------------
	i2cmc_sync3 #(
		.W(2)
	) u_sync (
		.core_clk(core_clk),
		.rstn(rstn),
		.ce(ce),
		.d({scl_in, sda_in}),
		.q(pins_s)
	);

	assign scl_s = pins_s[1];
	assign sda_s = pins_s[0];

	i2cmc_fifo #(
		.W(i2cmc_pkg::DATA_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.core_clk(core_clk),
		.rstn(rstn),
		.ce(ce),
		.in_valid(s_q.push),
		.in_data(s_q.push_data),
		.in_ready(fifo_in_ready),
		.out_valid(fifo_out_valid),
		.out_data(fifo_out_data),
		.out_ready(fifo_pop),
		.level(fifo_level)
	);

	// --------------------------------------------------------------
	// apb decode
	// --------------------------------------------------------------
	// one wait state: pready rises in the second access cycle
	assign acc = psel && penable;
	assign acc_done = acc && s_q.pready;
	assign wr_done = acc_done && pwrite && !s_q.pslverr;
	assign rd_done = acc_done && !pwrite && !s_q.pslverr;
	assign fifo_pop = rd_done && (paddr == i2cmc_pkg::OFS_RXD);
	assign mode = {s_q.master_select_bit, s_q.transmit_select_bit};

	// --------------------------------------------------------------
	// next state
	// --------------------------------------------------------------
	always_comb begin
		logic scl_rise, scl_fall, start_det, stop_det, sync_f;
		logic [7:0] byte_in;
		s_d = s_q;
		sync_f = s_q.fmt_sync;
		scl_rise = scl_s && !s_q.scl_prev;
		scl_fall = !scl_s && s_q.scl_prev;
		start_det = !sync_f && scl_s && s_q.scl_prev &&
			s_q.sda_prev && !sda_s;
		stop_det = !sync_f && scl_s && s_q.scl_prev &&
			!s_q.sda_prev && sda_s;
		byte_in = {s_q.shreg[6:0], sda_s};
		s_d.scl_prev = scl_s;
		s_d.sda_prev = sda_s;
		s_d.push = 1'b0;

		// bus answer and read data
		s_d.pready = acc && !s_q.pready;
		if (acc && !s_q.pready) begin
			s_d.pslverr = 1'b0;
			s_d.prdata = 32'h0;
			unique case (paddr)
				i2cmc_pkg::OFS_CTRL: s_d.prdata[7:4] =
					{s_q.en, s_q.next_receive_block, s_q.master_select_bit, s_q.transmit_select_bit};
				i2cmc_pkg::OFS_FMT: s_d.prdata[i2cmc_pkg::FMT_SYNC] =
					s_q.fmt_sync;
				i2cmc_pkg::OFS_SAR: s_d.prdata[7:1] = s_q.own_slave_address;
				i2cmc_pkg::OFS_TXD: s_d.prdata[7:0] = s_q.txd;
				i2cmc_pkg::OFS_RXD: begin
					if (fifo_out_valid) begin
						s_d.prdata[7:0] = fifo_out_data;
					end
				end
				i2cmc_pkg::OFS_STAT: begin
					s_d.prdata[i2cmc_pkg::STAT_ARB] = s_q.arb_lost;
					s_d.prdata[i2cmc_pkg::STAT_OVR] = s_q.ovr;
					s_d.prdata[i2cmc_pkg::STAT_AHIT] = s_q.addr_hit;
					s_d.prdata[i2cmc_pkg::STAT_BUSY] =
						(s_q.state == i2cmc_pkg::ST_SHIFT);
					s_d.prdata[i2cmc_pkg::STAT_TXF] = s_q.tx_full;
					s_d.prdata[i2cmc_pkg::STAT_RXNE] = fifo_out_valid;
					s_d.prdata[i2cmc_pkg::STAT_MODE +: 2] = mode;
				end
				default: s_d.pslverr = 1'b1;
			endcase
		end else begin
			// error flag stands only with pready
			s_d.pslverr = 1'b0;
		end

		// register writes; hardware updates below take priority
		if (wr_done) begin
			unique case (paddr)
				i2cmc_pkg::OFS_CTRL: begin
					s_d.en = pwdata[i2cmc_pkg::CTRL_EN];
					s_d.next_receive_block = pwdata[i2cmc_pkg::CTRL_NEXT_RECEIVE_BLOCK];
					s_d.master_select_bit = pwdata[i2cmc_pkg::CTRL_MST];
					s_d.transmit_select_bit = pwdata[i2cmc_pkg::CTRL_TRS];
				end
				i2cmc_pkg::OFS_FMT: s_d.fmt_sync =
					pwdata[i2cmc_pkg::FMT_SYNC];
				i2cmc_pkg::OFS_SAR: s_d.own_slave_address = pwdata[7:1];
				i2cmc_pkg::OFS_TXD: begin
					s_d.txd = pwdata[7:0];
					s_d.tx_full = 1'b1;
				end
				i2cmc_pkg::OFS_STAT: begin
					if (pwdata[i2cmc_pkg::STAT_ARB]) s_d.arb_lost = 1'b0;
					if (pwdata[i2cmc_pkg::STAT_OVR]) s_d.ovr = 1'b0;
					if (pwdata[i2cmc_pkg::STAT_AHIT]) s_d.addr_hit = 1'b0;
				end
				default: ;
			endcase
		end

		// receive register read gates the next reception
		if (fifo_pop && !s_q.transmit_select_bit) begin
			s_d.rx_stop = s_q.next_receive_block;
		end

		if (!s_q.en) begin
			// halted: engine idle, pins back to port use
			s_d.state = i2cmc_pkg::ST_IDLE;
			s_d.scl_oe = 1'b0;
			s_d.sda_oe = 1'b0;
			s_d.scl_out = 1'b1;
			s_d.sda_out = 1'b1;
			s_d.pins_sel = 1'b0;
			s_d.phase = 1'b1;
		end else begin
			s_d.pins_sel = 1'b1;
			unique case (s_q.state)
				i2cmc_pkg::ST_IDLE: begin
					s_d.phase = 1'b1;
					s_d.bitcnt = 4'h0;
					if (s_q.master_select_bit && (s_q.transmit_select_bit ? s_q.tx_full : !s_q.rx_stop))
					begin
						// master start: modes 10 and 11
						s_d.state = i2cmc_pkg::ST_SHIFT;
						s_d.shreg = s_q.transmit_select_bit ? s_q.txd : 8'hff;
						s_d.tx_full = s_q.tx_full && !s_q.transmit_select_bit;
						s_d.phase = 1'b0;
						s_d.div = HALF_LD;
						s_d.addr_phase = 1'b0;
					end else if (!s_q.master_select_bit && start_det) begin
						s_d.state = i2cmc_pkg::ST_SHIFT;
						s_d.shreg = 8'hff;
						s_d.addr_phase = 1'b1;
					end else if (!s_q.master_select_bit && sync_f &&
						(s_q.transmit_select_bit ? s_q.tx_full :
						(!s_q.rx_stop && fifo_in_ready))) begin
						// synchronous slave waits for transmit data, or for fifo space to receive
						s_d.state = i2cmc_pkg::ST_SHIFT;
						s_d.shreg = s_q.transmit_select_bit ? s_q.txd : 8'hff;
						s_d.tx_full = s_q.tx_full && !s_q.transmit_select_bit;
						s_d.addr_phase = 1'b0;
					end
				end
				i2cmc_pkg::ST_SHIFT: begin
					// master paces the transfer clock
					if (s_q.master_select_bit) begin
						if (s_q.div == '0) begin
							s_d.div = HALF_LD;
							s_d.phase = !s_q.phase;
						end else begin
							s_d.div = s_q.div - 1'b1;
						end
					end
					// transmit steps to the next bit while the clock is low
					if (scl_fall && s_q.transmit_select_bit && s_q.bitcnt != 4'h0) begin
						s_d.shreg = {s_q.shreg[6:0], 1'b1};
					end
					if (scl_rise) begin
						if (!sync_f && s_q.master_select_bit && s_q.transmit_select_bit &&
							s_q.shreg[7] && !sda_s) begin
							// another master pulled data low
							s_d.master_select_bit = 1'b0;
							s_d.transmit_select_bit = 1'b0;
							s_d.arb_lost = 1'b1;
							s_d.state = i2cmc_pkg::ST_IDLE;
						end else begin
							s_d.bitcnt = s_q.bitcnt + 4'h1;
							// receive collects the sampled bit, msb first
							if (!s_q.transmit_select_bit) begin
								s_d.shreg = byte_in;
							end
							if (s_q.bitcnt == 4'h7) begin
								s_d.state = i2cmc_pkg::ST_IDLE;
								if (s_q.addr_phase) begin
									if (byte_in[7:1] == s_q.own_slave_address && byte_in[0])
									begin
										s_d.transmit_select_bit = 1'b1;
										s_d.addr_hit = 1'b1;
									end
									s_d.state = i2cmc_pkg::ST_SHIFT;
									s_d.addr_phase = 1'b0;
									s_d.bitcnt = 4'h0;
									s_d.shreg = 8'hff;
								end else if (!s_q.transmit_select_bit) begin
									if (fifo_in_ready) begin
										s_d.push = 1'b1;
										s_d.push_data = byte_in;
									end else begin
										s_d.ovr = 1'b1;
										if (sync_f && s_q.master_select_bit) begin
											s_d.master_select_bit = 1'b0;
										end
									end
								end
							end
						end
					end
					if (stop_det) begin
						s_d.state = i2cmc_pkg::ST_IDLE;
					end
				end
			endcase

			// pin drive: synchronous is push-pull, two-wire open drain
			if (sync_f) begin
				s_d.scl_oe = s_q.master_select_bit;
				s_d.scl_out = s_d.phase;
				s_d.sda_oe = s_d.transmit_select_bit;
				s_d.sda_out = s_d.shreg[7];
			end else begin
				s_d.scl_oe = s_q.master_select_bit && !s_d.phase;
				s_d.scl_out = 1'b0;
				s_d.sda_oe = (s_d.state == i2cmc_pkg::ST_SHIFT) &&
					s_d.transmit_select_bit && !s_d.shreg[7];
				s_d.sda_out = 1'b0;
			end
		end
	end

	// --------------------------------------------------------------
	// state register
	// --------------------------------------------------------------
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			s_q <= '0;
			s_q.state <= i2cmc_pkg::ST_IDLE;
			s_q.en <= i2cmc_pkg::CTRL_RST[i2cmc_pkg::CTRL_EN];
			s_q.own_slave_address <= i2cmc_pkg::SAR_RST;
			s_q.phase <= 1'b1;
			s_q.scl_prev <= 1'b1;
			s_q.sda_prev <= 1'b1;
			s_q.scl_out <= 1'b1;
			s_q.sda_out <= 1'b1;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	// outputs straight from the state register
	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign scl_out = s_q.scl_out;
	assign scl_oe = s_q.scl_oe;
	assign sda_out = s_q.sda_out;
	assign sda_oe = s_q.sda_oe;
	assign pins_bus_sel = s_q.pins_sel;

endmodule : i2cmc_ctrl

// ===== common/i2cmc_pkg.sv
// Purpose: shared constants and types of the two-wire mode control block
// Assumes: 32-bit apb data, one register per aligned word
// Notes: offsets are byte addresses

package i2cmc_pkg;

	// --------------------------------------------------------------
	// register map
	// --------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_CTRL = 8'h00; // bus_control_first
	localparam logic [7:0] OFS_FMT = 8'h04; // format select
	localparam logic [7:0] OFS_SAR = 8'h08; // own_slave_address
	localparam logic [7:0] OFS_TXD = 8'h0c; // transmit data
	localparam logic [7:0] OFS_RXD = 8'h10; // receive_data_reg
	localparam logic [7:0] OFS_STAT = 8'h14; // status, write 1 to clear

	// --------------------------------------------------------------
	// field positions and reset values
	// --------------------------------------------------------------
	localparam int CTRL_EN = 7; // interface_enable_bit
	localparam int CTRL_NEXT_RECEIVE_BLOCK = 6; // next_receive_block
	localparam int CTRL_MST = 5; // master_select_bit
	localparam int CTRL_TRS = 4; // transmit_select_bit
	localparam int FMT_SYNC = 0; // 1: clocked synchronous format
	localparam int SAR_LO = 1; // address sits in bits 7:1
	localparam int STAT_ARB = 0;
	localparam int STAT_OVR = 1;
	localparam int STAT_AHIT = 2;
	localparam int STAT_BUSY = 3;
	localparam int STAT_TXF = 4;
	localparam int STAT_RXNE = 5;
	localparam int STAT_MODE = 6; // mode pair in bits 7:6
	localparam logic [7:0] CTRL_RST = 8'h00;
	localparam logic [6:0] SAR_RST = 7'h00;

	// --------------------------------------------------------------
	// modes and timing
	// --------------------------------------------------------------
	localparam logic [1:0] MODE_SLV_RX = 2'h0;
	localparam logic [1:0] MODE_SLV_TX = 2'h1;
	localparam logic [1:0] MODE_MST_RX = 2'h2;
	localparam logic [1:0] MODE_MST_TX = 2'h3;
	localparam int CLK_NS = 4; // core_clk period
	localparam int HALF_NS = 2000; // half period of the transfer clock
	localparam int HALF_CYC = HALF_NS / CLK_NS;
	localparam int DIV_W = 10;
	localparam int DATA_W = 8;
	localparam int FIFO_DEPTH = 8;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SHIFT
	} i2cmc_state_type;

endpackage : i2cmc_pkg

// ===== core/i2cmc_sync3.sv
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: inputs are asynchronous to core_clk
// Notes: output changes once stages two and three agree

`timescale 1ns/1ns

module i2cmc_sync3 #(
	parameter int W = 2
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} i2cmc_sync_type;

	i2cmc_sync_type s_q, s_d;

	// --------------------------------------------------------------
	// next state
	// --------------------------------------------------------------
	// first stage feeds only the second; the filter sees stages 2 and 3
	always_comb begin
		s_d = s_q;
		s_d.s1 = d;
		s_d.s2 = s_q.s1;
		s_d.s3 = s_q.s2;
		for (int i = 0; i < W; i++) begin
			if (s_q.s2[i] == s_q.s3[i]) begin
				s_d.q[i] = s_q.s3[i];
			end
		end
	end

	// state register; lines idle high
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			s_q <= '1;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

	assign q = s_q.q;

endmodule : i2cmc_sync3

// ===== core/i2cmc_fifo.sv
// Purpose: small synchronous fifo with valid/ready on both sides
// Assumes: one clock, synchronous active-low reset
// Notes: full and empty come from pointers with a wrap bit

`timescale 1ns/1ns

module i2cmc_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 8
) (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic ce,
	input wire logic in_valid,
	input wire logic [W-1:0] in_data,
	output logic in_ready,
	output logic out_valid,
	output logic [W-1:0] out_data,
	input wire logic out_ready,
	output logic [$clog2(DEPTH):0] level
);

	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW:0] wp;
		logic [AW:0] rp;
	} i2cmc_fifo_type;

	i2cmc_fifo_type s_q, s_d;
	logic full, empty;

	// --------------------------------------------------------------
	// flags and next state
	// --------------------------------------------------------------
	assign full = (s_q.wp[AW] != s_q.rp[AW]) &&
		(s_q.wp[AW-1:0] == s_q.rp[AW-1:0]);
	assign empty = (s_q.wp == s_q.rp);
	assign in_ready = !full;
	assign out_valid = !empty;
	assign out_data = s_q.mem[s_q.rp[AW-1:0]];
	assign level = s_q.wp - s_q.rp;

	// push and pop may happen together
	always_comb begin
		s_d = s_q;
		if (in_valid && !full) begin
			s_d.mem[s_q.wp[AW-1:0]] = in_data;
			s_d.wp = s_q.wp + 1'b1;
		end
		if (out_ready && !empty) begin
			s_d.rp = s_q.rp + 1'b1;
		end
	end

	// state register
	always_ff @(posedge core_clk) begin
		if (!rstn) begin
			s_q <= '0;
		end else if (ce) begin
			s_q <= s_d;
		end
	end

endmodule : i2cmc_fifo

// ===== tb/i2cmc_ctrl_monitor.sv
// Purpose: port checks of the mode control block
// Assumes: apb slave answering after one wait state
// Notes: bound to every i2cmc_ctrl instance
`timescale 1ns/1ns
module i2cmc_ctrl_monitor (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [7:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic scl_oe,
	input wire logic sda_oe,
	input wire logic pins_bus_sel
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rstn);
	// ----------------------------------------------------------
	// transfer steps
	// ----------------------------------------------------------
	sequence s_setup;
		psel && !penable;
	endsequence
	sequence s_access;
		psel && penable;
	endsequence
	sequence s_ctrl_wr;
		s_access ##0 pready && pwrite && paddr == i2cmc_pkg::OFS_CTRL;
	endsequence
	// ----------------------------------------------------------
	// checks
	// ----------------------------------------------------------
	a_one_wait: assert property (s_setup ##1 s_access |-> !pready ##1 pready)
		else $error("apb answer not after one wait state");
	a_ready_access: assert property (pready |-> psel && penable)
		else $error("pready outside an access phase");
	a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
		else $error("error answer without ready or with data");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_halt_pins: assert property (!pins_bus_sel |-> !scl_oe && !sda_oe)
		else $error("pins driven while in port use");
	a_enable_on: assert property (s_ctrl_wr ##0 pwdata[7] |=> ##[0:1] pins_bus_sel)
		else $error("enable write did not select bus pins");
	a_enable_off: assert property (s_ctrl_wr ##0 !pwdata[7] |=> ##[0:1] !pins_bus_sel)
		else $error("disable write did not return pins");
	a_reset_halt: assert property ($rose(rstn) |-> !pins_bus_sel && !scl_oe)
		else $error("block not halted after reset");
endmodule : i2cmc_ctrl_monitor

bind i2cmc_ctrl i2cmc_ctrl_monitor i2cmc_ctrl_monitor_inst (
	.core_clk(core_clk), .rstn(rstn), .paddr(paddr), .psel(psel),
	.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
	.prdata(prdata), .pready(pready), .pslverr(pslverr),
	.scl_oe(scl_oe), .sda_oe(sda_oe), .pins_bus_sel(pins_bus_sel)
);

// ===== tb/i2cmc_far_model.sv
// Purpose: far side of the serial bus
// Assumes: pull-ups on both lines in two-wire use
// Notes: sync slave sends a5, a6, ... msb first
`timescale 1ns/1ns
module i2cmc_far_model (
	input wire logic core_clk,
	input wire logic scl,
	input wire logic arb_lose,
	input wire logic sync_on,
	output logic p_scl,
	output logic p_sda
);
	logic [7:0] tx_q = 8'ha5;
	logic [2:0] cnt_q = 3'h0;
	logic bit_q = 1'b1;
	logic tw_q = 1'b1;
	initial p_scl = 1'b1;
	// a held low data line makes a released master bit lose
	assign p_sda = arb_lose ? 1'b0 : (sync_on ? bit_q : tw_q);
	// sync slave: next bit at each falling clock, msb first
	always @(negedge scl) begin
		if (sync_on) begin
			bit_q <= tx_q[3'h7 - cnt_q];
			cnt_q <= cnt_q + 3'h1;
			if (cnt_q == 3'h7)
				tx_q <= tx_q + 8'h01;
		end
	end
	// one bus phase, long enough for the input filter
	task automatic hold(input logic c, input logic d);
		p_scl <= c;
		tw_q <= d;
		repeat (12) @(posedge core_clk);
	endtask : hold
	// two-wire master: start, eight bits msb first, stop
	task automatic send_byte(input logic [7:0] b);
		hold(1'b1, 1'b0);
		for (int i = 7; i >= 0; i--) begin
			hold(1'b0, b[i]);
			hold(1'b1, b[i]);
		end
		hold(1'b0, 1'b0);
		hold(1'b1, 1'b0);
		hold(1'b1, 1'b1);
	endtask : send_byte
endmodule : i2cmc_far_model

// ===== tb/i2cmc_ctrl_tb_top.sv
// Purpose: register level test of the mode control block
// Assumes: transfer clock half period of 8 cycles, above pin input latency
// Notes: apb tasks wait for pready under a bound
`timescale 1ns/1ns
module i2cmc_ctrl_tb_top;
	logic core_clk, rstn, ce, psel, penable, pwrite;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic pready, pslverr, scl_out, scl_oe, sda_out, sda_oe;
	logic pins_bus_sel, arb_lose, sync_on, p_scl, p_sda;
	int err_total = 0;
	int num_checks = 0;
	// wired lines: pull-up, any driver wins low
	wire logic scl = (scl_oe ? scl_out : 1'b1) & p_scl;
	wire logic sda = (sda_oe ? sda_out : 1'b1) & p_sda;
	always #2 core_clk = ~core_clk;
	i2cmc_ctrl #(.HALF_CYC(8)) i2cmc_ctrl_inst (
		.core_clk(core_clk), .rstn(rstn), .ce(ce), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .scl_in(scl), .scl_out(scl_out),
		.scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out),
		.sda_oe(sda_oe), .pins_bus_sel(pins_bus_sel));
	i2cmc_far_model i2cmc_far_model_inst (
		.core_clk(core_clk), .scl(scl), .arb_lose(arb_lose),
		.sync_on(sync_on), .p_scl(p_scl), .p_sda(p_sda));
	// ----------------------------------------------------------
	// tasks
	// ----------------------------------------------------------
	task automatic give_verdict;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : give_verdict
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		num_checks++;
		if (g !== e) begin
			err_total++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	// one apb transfer, held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] wd, output logic [31:0] rd, output logic er);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge core_clk);
		penable <= 1'b1;
		do begin
			@(posedge core_clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		if (n >= 20) begin
			err_total++;
			give_verdict;
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge core_clk);
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] x, input string nm);
		logic [31:0] r;
		logic e;
		apb(1'b0, a, 32'h0, r, e);
		chk(nm, x, r & m);
	endtask : rd
	// ----------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------
	initial begin
		logic [31:0] d;
		logic e;
		core_clk = 0; rstn = 0; ce = 1; psel = 0; penable = 0;
		pwrite = 0; paddr = 0; pwdata = 0; arb_lose = 0; sync_on = 0;
		repeat (5) @(posedge core_clk);
		rstn <= 1'b1;
		@(posedge core_clk);
		rd(i2cmc_pkg::OFS_CTRL, 32'hff, 32'h0, "ctrl_reset");
		for (int m = 0; m < 4; m++) begin
			wr(i2cmc_pkg::OFS_CTRL, m << 4);
			rd(i2cmc_pkg::OFS_STAT, 32'hc0, m << 6, "mode");
		end
		chk("halt_pins", 0, {pins_bus_sel, scl_oe, sda_oe});
		apb(1'b0, 8'h18, 32'h0, d, e);
		chk("unmapped_err", 1, e);
		chk("unmapped_data", 0, d);
		// sync master receive: fill fifo until a byte is lost
		wr(i2cmc_pkg::OFS_FMT, 32'h1);
		sync_on <= 1'b1;
		wr(i2cmc_pkg::OFS_CTRL, 32'ha0);
		@(posedge core_clk);
		chk("bus_sel", 1, pins_bus_sel);
		repeat (30) @(posedge core_clk);
		chk("sync_clk_oe", 1, scl_oe);
		repeat (1500) @(posedge core_clk);
		rd(i2cmc_pkg::OFS_CTRL, 32'hff, 32'h80, "ovr_mode");
		rd(i2cmc_pkg::OFS_STAT, 32'h02, 32'h02, "ovr_flag");
		// drain with reception blocked, then read zero when empty
		wr(i2cmc_pkg::OFS_CTRL, 32'hc0);
		for (int k = 0; k < 8; k++)
			rd(i2cmc_pkg::OFS_RXD, 32'hff, 8'ha5 + k, "rx_data");
		rd(i2cmc_pkg::OFS_RXD, 32'hffffffff, 32'h0, "rx_empty");
		wr(i2cmc_pkg::OFS_CTRL, 32'he0);
		repeat (200) @(posedge core_clk);
		rd(i2cmc_pkg::OFS_STAT, 32'h28, 32'h0, "rx_blocked");
		wr(i2cmc_pkg::OFS_CTRL, 32'ha0);
		rd(i2cmc_pkg::OFS_RXD, 32'hff, 32'h0, "rx_empty2");
		repeat (200) @(posedge core_clk);
		rd(i2cmc_pkg::OFS_STAT, 32'h20, 32'h20, "rx_resumed");
		// block again: the byte in flight ends, then the master rests
		wr(i2cmc_pkg::OFS_CTRL, 32'he0);
		rd(i2cmc_pkg::OFS_RXD, 32'hff, 32'hae, "rx_next");
		repeat (200) @(posedge core_clk);
		rd(i2cmc_pkg::OFS_STAT, 32'h08, 32'h0, "rx_halted");
		wr(i2cmc_pkg::OFS_CTRL, 32'h80);
		repeat (100) @(posedge core_clk);
		sync_on <= 1'b0;
		wr(i2cmc_pkg::OFS_STAT, 32'h07);
		// two-wire master transmit loses arbitration
		wr(i2cmc_pkg::OFS_FMT, 32'h0);
		wr(i2cmc_pkg::OFS_CTRL, 32'hb0);
		// hold data low only once this side is master
		arb_lose <= 1'b1;
		wr(i2cmc_pkg::OFS_TXD, 32'hff);
		repeat (100) @(posedge core_clk);
		rd(i2cmc_pkg::OFS_CTRL, 32'hff, 32'h80, "arb_mode");
		rd(i2cmc_pkg::OFS_STAT, 32'h01, 32'h01, "arb_flag");
		arb_lose <= 1'b0;
		// own address with read bit turns slave to transmit
		wr(i2cmc_pkg::OFS_SAR, 32'h6c);
		i2cmc_far_model_inst.send_byte(8'h6d);
		rd(i2cmc_pkg::OFS_CTRL, 32'hff, 32'h90, "addr_trs");
		rd(i2cmc_pkg::OFS_STAT, 32'hc4, 32'h44, "addr_hit");
		wr(i2cmc_pkg::OFS_CTRL, 32'h0);
		@(posedge core_clk);
		chk("off_pins", 0, {pins_bus_sel, scl_oe, sda_oe});
		give_verdict;
	end
endmodule : i2cmc_ctrl_tb_top
